/* hw/touch_adc_result_dac_gpio_regs.sv */
// Register bank: output converter control, conversion results, pin control
//
// Notes on behaviour
// - Control bit 0 picks voltage span: 0 half supply, 1 full supply.
// - Control bit 2 picks output type: 0 voltage, 1 current.
// - Control bit 3 powers converter down; word resets to 0x008.
// - Control word at write 1110, read 01110; code in bits 4..11.
// - Vertical position result readable at 10000, read only.
// - Horizontal position result readable at 10001, read only.
// - Second pressure term readable at 10010, read only.
// - First pressure term readable at 11010, read only.
// - Auxiliary results at 10011, 10100, 10101, reset to zero.
// - Battery results at 10110 and 10111, reset to zero.
// - Temperature results at 11000 and 11001, reset to zero.
// - Top four bits 1111 select the extended write map.
// - Next four bits select pin register, last eight carry data.
// - Reads use a 5-bit address, data shifts out on serial output.
// - First pin control written at 1111 0000, read at 11011.
// - Bits 0 and 4 enable pin two and pin one alerts.
// - Bits 1 and 5 set pin direction: 0 output, 1 input.
// - Bits 2 and 6 set pin polarity: 0 low, 1 high active.
// - Bits 3 and 7 pick pin function: 0 analog, 1 general.
`timescale 1ns/10ps
`include "touch_regs_map.svh"

module touch_adc_result_dac_gpio_regs #(
    parameter int RES_W  = 12,
    parameter int WORD_W = 16
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       clk_en,
    input  wire logic                       ser_cs_n,
    input  wire logic                       ser_clk,
    input  wire logic                       ser_din,
    output logic                            ser_dout,
    output logic                            ser_dout_oe,
    input  wire touch_regs_pkg::read_addr_t read_address,
    input  wire logic                       result_valid,
    input  wire touch_regs_pkg::read_addr_t result_channel,
    input  wire logic [RES_W-1:0]           result_data,
    output logic                            output_span_full,
    output logic                            output_current_mode,
    output logic                            converter_power_down,
    output logic [7:0]                      output_code,
    output logic                            pin_two_alert_enable,
    output logic                            pin_two_direction,
    output logic                            pin_two_polarity,
    output logic                            pin_two_function_select,
    output logic                            pin_one_alert_enable,
    output logic                            pin_one_direction,
    output logic                            pin_one_polarity,
    output logic                            pin_one_function_select
);

    touch_regs_pkg::frame_state_t     frame_state;
    logic [3:0]                       bit_count;
    logic                             ser_clk_prev;
    logic [WORD_W-1:0]                shift_in;
    logic [WORD_W-1:0]                shift_out;
    logic [11:0]                      out_ctrl;
    logic [7:0]                       pin_ctrl;
    logic [`RES_COUNT-1:0][RES_W-1:0] results;
    logic                             clk_rise;
    logic                             clk_fall;
    logic                             frame_start;
    logic                             commit;
    logic [WORD_W-1:0]                commit_word;
    logic                             ext_write;
    logic                             ctrl_write;
    logic                             pin_write;
    logic                             result_hit;

    // Result slot for an address, valid only inside the result window
    function automatic logic [3:0] result_index(
        input touch_regs_pkg::read_addr_t addr
    );
        logic [4:0] diff;
        diff = addr - `RES_FIRST_RADDR;
        return diff[3:0];
    endfunction

    function automatic logic in_results(
        input touch_regs_pkg::read_addr_t addr
    );
        return (addr >= `RES_FIRST_RADDR) && (addr <= `RES_LAST_RADDR);
    endfunction

    // Unmapped addresses read as zero
    function automatic logic [11:0] read_value(
        input touch_regs_pkg::read_addr_t addr
    );
        logic [11:0] val;
        val = 12'h000;
        if (addr == `OCTL_RADDR) begin
            val = out_ctrl;
        end else if (addr == `GPC1_RADDR) begin
            val = {4'h0, pin_ctrl};
        end else if (in_results(addr)) begin
            val = results[result_index(addr)];
        end
        return val;
    endfunction

    // Serial clock is sampled, so it must run well below ref_clk
    assign clk_rise    = ser_clk && !ser_clk_prev;
    assign clk_fall    = !ser_clk && ser_clk_prev;
    assign frame_start = !ser_cs_n &&
                         (frame_state == touch_regs_pkg::FRAME_IDLE);
    assign commit      = clk_en && !ser_cs_n && clk_rise &&
                         (frame_state == touch_regs_pkg::FRAME_SHIFT) &&
                         (bit_count == `FRAME_LAST_BIT);
    assign commit_word = {shift_in[WORD_W-2:0], ser_din};
    assign ext_write   = commit &&
                         (commit_word[15:12] == `EXT_PREFIX);
    assign ctrl_write  = commit &&
                         (commit_word[15:12] == `OCTL_WADDR);
    assign pin_write   = ext_write &&
                         (commit_word[11:8] == `GPC1_WADDR);
    assign result_hit  = clk_en && result_valid && in_results(result_channel);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ser_clk_prev <= 1'b0;
        end else if (clk_en) begin
            ser_clk_prev <= ser_clk;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_state <= touch_regs_pkg::FRAME_IDLE;
            bit_count   <= 4'h0;
            shift_in    <= '0;
        end else if (clk_en) begin
            if (ser_cs_n) begin
                frame_state <= touch_regs_pkg::FRAME_IDLE;
                bit_count   <= 4'h0;
            end else begin
                unique case (frame_state)
                    touch_regs_pkg::FRAME_IDLE: begin
                        frame_state <= touch_regs_pkg::FRAME_SHIFT;
                        bit_count   <= 4'h0;
                    end
                    touch_regs_pkg::FRAME_SHIFT: begin
                        if (clk_rise) begin
                            shift_in  <= commit_word;
                            bit_count <= bit_count + 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Read data is captured when the frame opens, MSB first, upper nibble 0
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_out <= '0;
        end else if (clk_en) begin
            if (frame_start) begin
                shift_out <= {4'h0, read_value(read_address)};
            end else if (!ser_cs_n && clk_fall) begin
                shift_out <= {shift_out[WORD_W-2:0], 1'b0};
            end
        end
    end

    assign ser_dout    = shift_out[WORD_W-1];
    assign ser_dout_oe = !ser_cs_n;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_ctrl <= `OCTL_RESET;
        end else if (ctrl_write) begin
            out_ctrl <= commit_word[11:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_ctrl <= `GPC1_RESET;
        end else if (pin_write) begin
            pin_ctrl <= commit_word[7:0];
        end
    end

    // No write path reaches the results: conversions are their only source
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            results <= '0;
        end else if (result_hit) begin
            results[result_index(result_channel)] <= result_data;
        end
    end

    assign output_span_full        = out_ctrl[`OCTL_SPAN_BIT];
    assign output_current_mode     = out_ctrl[`OCTL_MODE_BIT];
    assign converter_power_down    = out_ctrl[`OCTL_OFF_BIT];
    assign output_code = out_ctrl[`OCTL_CODE_MSB:`OCTL_CODE_LSB];
    assign pin_two_alert_enable    = pin_ctrl[`GPC1_P2_ALERT];
    assign pin_two_direction       = pin_ctrl[`GPC1_P2_DIR];
    assign pin_two_polarity        = pin_ctrl[`GPC1_P2_POL];
    assign pin_two_function_select = pin_ctrl[`GPC1_P2_FUNC];
    assign pin_one_alert_enable    = pin_ctrl[`GPC1_P1_ALERT];
    assign pin_one_direction       = pin_ctrl[`GPC1_P1_DIR];
    assign pin_one_polarity        = pin_ctrl[`GPC1_P1_POL];
    assign pin_one_function_select = pin_ctrl[`GPC1_P1_FUNC];

    // Properties share one clock and are dropped while reset is asserted
    default clocking chk_clk @(posedge ref_clk);
    endclocking

    default disable iff (rst);

    sequence ctrl_write_s;
        ctrl_write;
    endsequence

    sequence pin_write_s;
        pin_write;
    endsequence

    // A frame opening with a given read address selects the answer word
    sequence read_open_s(logic [4:0] addr);
        clk_en && frame_start && read_address == addr;
    endsequence

    // A conversion strobe aimed at one result slot
    sequence result_strobe_s(logic [4:0] chan);
        result_hit && result_channel == chan;
    endsequence

    sequence reset_release_s;
        $fell(rst);
    endsequence

    chk_span_write: assert property (
        ctrl_write_s |=> output_span_full == $past(commit_word[0]))
        else $error("span bit not taken from write");

    chk_mode_write: assert property (
        ctrl_write_s |=> output_current_mode == $past(commit_word[2]))
        else $error("mode bit not taken from write");

    chk_power_write: assert property (
        ctrl_write_s |=> converter_power_down == $past(commit_word[3]))
        else $error("power down bit not taken from write");

    chk_power_reset: assert property (
        reset_release_s |-> converter_power_down && output_code == 8'h00 &&
        !output_span_full && !output_current_mode)
        else $error("converter not powered down after reset");

    chk_code_order: assert property (
        ctrl_write_s |=> output_code == $past(commit_word[11:4]))
        else $error("output code misplaced");

    chk_ctrl_hold: assert property (
        commit && !ctrl_write |=> $stable(out_ctrl))
        else $error("control word changed by another address");

    chk_read_ctrl: assert property (
        read_open_s(`OCTL_RADDR) |=> shift_out == {4'h0, $past(out_ctrl)})
        else $error("control word read data wrong");

    chk_result_load: assert property (
        result_strobe_s(`RES_VPOS_RADDR) |=> results[0] == $past(result_data))
        else $error("vertical result not loaded");

    chk_hpos_load: assert property (
        result_strobe_s(`RES_HPOS_RADDR) |=> results[1] == $past(result_data))
        else $error("horizontal result not loaded");

    chk_ptwo_load: assert property (
        result_strobe_s(`RES_PTWO_RADDR) |=> results[2] == $past(result_data))
        else $error("second pressure result not loaded");

    chk_pone_load: assert property (
        result_strobe_s(`RES_PONE_RADDR) |=> results[10] == $past(result_data))
        else $error("first pressure result not loaded");

    chk_aux_load: assert property (
        result_strobe_s(`RES_AUX_THR_RADDR) |=> results[5] == $past(result_data))
        else $error("auxiliary result not loaded");

    chk_batt_load: assert property (
        result_strobe_s(`RES_BATT_TWO_RADDR)
        |=> results[7] == $past(result_data))
        else $error("battery result not loaded");

    chk_temp_load: assert property (
        result_strobe_s(`RES_TDIF_RADDR) |=> results[9] == $past(result_data))
        else $error("temperature result not loaded");

    chk_result_reset: assert property (
        reset_release_s |-> results == '0)
        else $error("results not cleared by reset");

    chk_ext_isolated: assert property (
        ext_write |=> $stable(out_ctrl))
        else $error("extended write touched control word");

    chk_ext_pin: assert property (
        pin_write_s |=> pin_two_alert_enable == $past(commit_word[0]) &&
        pin_one_function_select == $past(commit_word[7]))
        else $error("pin control not written");

    chk_pin_hold: assert property (
        commit && !pin_write |=> $stable(pin_ctrl))
        else $error("pin control changed by another address");

    chk_read_load: assert property (
        read_open_s(`GPC1_RADDR) |=> shift_out == {8'h00, $past(pin_ctrl)})
        else $error("pin control read data wrong");

    // Result reads carry the slot picked by the address at frame open
    chk_read_result: assert property (
        clk_en && frame_start && in_results(read_address)
        |=> shift_out ==
            {4'h0, $past(results[result_index(read_address)])})
        else $error("result read data wrong");

    // Each sampled fall of the serial clock moves the answer one bit
    chk_dout_shift: assert property (
        clk_en && !ser_cs_n && clk_fall && !frame_start
        |=> shift_out == {$past(shift_out[WORD_W-2:0]), 1'b0})
        else $error("read data did not shift");

    chk_pin_reset: assert property (
        reset_release_s |-> pin_ctrl == `GPC1_RESET)
        else $error("pin control not cleared by reset");

    chk_pin_alert: assert property (
        pin_write_s |=> pin_one_alert_enable == $past(commit_word[4]))
        else $error("pin one alert enable not written");

    chk_pin_dir: assert property (
        pin_write_s |=> pin_two_direction == $past(commit_word[1]) &&
        pin_one_direction == $past(commit_word[5]))
        else $error("pin direction not written");

    chk_pin_pol: assert property (
        pin_write_s |=> pin_two_polarity == $past(commit_word[2]) &&
        pin_one_polarity == $past(commit_word[6]))
        else $error("pin polarity not written");

    chk_pin_func: assert property (
        pin_write_s |=> pin_two_function_select == $past(commit_word[3]))
        else $error("pin two function not written");

    chk_result_hold: assert property (
        commit && !result_hit |=> $stable(results))
        else $error("serial write changed a result");

    // A low enable must freeze every stored value, results included
    chk_frozen: assert property (
        !clk_en |=> $stable(results) && $stable(out_ctrl) &&
        $stable(pin_ctrl) && $stable(shift_out))
        else $error("state moved while enable was low");

endmodule // touch_adc_result_dac_gpio_regs

/* common/touch_regs_map.svh */
// Register addresses, field positions and reset values of the register bank
`ifndef TOUCH_REGS_MAP_SVH
`define TOUCH_REGS_MAP_SVH

`define OCTL_WADDR        4'hE
`define OCTL_RADDR        5'h0E
`define OCTL_RESET        12'h008
`define OCTL_SPAN_BIT     0
`define OCTL_MODE_BIT     2
`define OCTL_OFF_BIT      3
`define OCTL_CODE_LSB     4
`define OCTL_CODE_MSB     11

`define RES_VPOS_RADDR    5'h10
`define RES_HPOS_RADDR    5'h11
`define RES_PTWO_RADDR    5'h12
`define RES_AUX_ONE_RADDR 5'h13
`define RES_AUX_TWO_RADDR 5'h14
`define RES_AUX_THR_RADDR 5'h15
`define RES_BATT_ONE_RADDR 5'h16
`define RES_BATT_TWO_RADDR 5'h17
`define RES_TSE_RADDR     5'h18
`define RES_TDIF_RADDR    5'h19
`define RES_PONE_RADDR    5'h1A
`define RES_FIRST_RADDR   5'h10
`define RES_LAST_RADDR    5'h1A
`define RES_COUNT         11
`define RES_RESET         12'h000

`define EXT_PREFIX        4'hF
`define GPC1_WADDR        4'h0
`define GPC1_RADDR        5'h1B
`define GPC1_RESET        8'h00
`define GPC1_P2_ALERT     0
`define GPC1_P2_DIR       1
`define GPC1_P2_POL       2
`define GPC1_P2_FUNC      3
`define GPC1_P1_ALERT     4
`define GPC1_P1_DIR       5
`define GPC1_P1_POL       6
`define GPC1_P1_FUNC      7

`define FRAME_BITS        16
`define FRAME_LAST_BIT    4'hF

`endif

/* common/touch_regs_pkg.sv */
// Types shared by the touch converter register bank
package touch_regs_pkg;
    typedef enum logic [0:0] {FRAME_IDLE, FRAME_SHIFT} frame_state_t;
    typedef logic [4:0] read_addr_t;
endpackage

/* verif/touch_host_model.sv */
// Host processor model driving the serial link of the register bank
`timescale 1ns/10ps

module touch_host_model (
    input  wire logic                  ref_clk,
    output logic                       ser_cs_n,
    output logic                       ser_clk,
    output logic                       ser_din,
    output touch_regs_pkg::read_addr_t read_address,
    input  wire logic                  ser_dout
);
    initial begin
        ser_cs_n = 1'b1;
        ser_clk = 1'b0;
        ser_din = 1'b0;
        read_address = 5'h00;
    end

    // Each serial clock level is held hp cycles; 2 is the fastest legal pace
    task automatic frame(input logic [15:0] word,
                         input touch_regs_pkg::read_addr_t ra,
                         input int hp,
                         output logic [15:0] rd);
        @(negedge ref_clk);
        read_address = ra;
        ser_cs_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        for (int i = 15; i >= 0; i--) begin
            ser_din = word[i];
            repeat (hp) @(negedge ref_clk);
            ser_clk = 1'b1;
            repeat (hp) @(negedge ref_clk);
            rd[i] = ser_dout;
            ser_clk = 1'b0;
        end
        repeat (hp) @(negedge ref_clk);
        ser_cs_n = 1'b1;
        // Released data line must not keep its last value
        ser_din = ~ser_din;
        @(negedge ref_clk);
    endtask
endmodule // touch_host_model

/* verif/touch_adc_result_dac_gpio_regs_bench.sv */
// Self-checking bench of the touch converter register bank
`timescale 1ns/10ps
`include "touch_regs_map.svh"

module touch_adc_result_dac_gpio_regs_bench;
    typedef struct packed {
        touch_regs_pkg::read_addr_t ch;
        logic [11:0]                val;
    } row_t;
    logic                       ref_clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       clk_en = 1'b1;
    logic                       result_valid = 1'b0;
    touch_regs_pkg::read_addr_t result_channel = 5'h00;
    logic [11:0]                result_data = 12'h000;
    logic                       ser_cs_n, ser_clk, ser_din;
    logic                       ser_dout, ser_dout_oe;
    touch_regs_pkg::read_addr_t read_address;
    logic                       span, cur, pd;
    logic [7:0]                 code, pin;
    logic [15:0]                rd;
    int                         miscompares = 0;
    int                         n_tests = 0;
    int                         cycles = 0;
    row_t rows [11] = '{'{`RES_VPOS_RADDR, 12'hFFF},
        '{`RES_HPOS_RADDR, 12'h001}, '{`RES_PTWO_RADDR, 12'h5A5},
        '{`RES_AUX_ONE_RADDR, 12'hA5A}, '{`RES_AUX_TWO_RADDR, 12'h123},
        '{`RES_AUX_THR_RADDR, 12'h800}, '{`RES_BATT_ONE_RADDR, 12'h7FF},
        '{`RES_BATT_TWO_RADDR, 12'h3C3}, '{`RES_TSE_RADDR, 12'hC3C},
        '{`RES_TDIF_RADDR, 12'h0F0}, '{`RES_PONE_RADDR, 12'hE01}};

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    touch_adc_result_dac_gpio_regs dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .ser_cs_n(ser_cs_n), .ser_clk(ser_clk), .ser_din(ser_din),
        .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
        .read_address(read_address), .result_valid(result_valid),
        .result_channel(result_channel), .result_data(result_data),
        .output_span_full(span), .output_current_mode(cur),
        .converter_power_down(pd), .output_code(code),
        .pin_two_alert_enable(pin[0]), .pin_two_direction(pin[1]),
        .pin_two_polarity(pin[2]), .pin_two_function_select(pin[3]),
        .pin_one_alert_enable(pin[4]), .pin_one_direction(pin[5]),
        .pin_one_polarity(pin[6]), .pin_one_function_select(pin[7]));

    touch_host_model host (
        .ref_clk(ref_clk), .ser_cs_n(ser_cs_n), .ser_clk(ser_clk),
        .ser_din(ser_din), .read_address(read_address),
        .ser_dout(ser_dout));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read frames carry write address 0000, which this bank ignores
    task automatic wr(input logic [15:0] w);
        logic [15:0] d;
        host.frame(w, 5'h00, 2, d);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        check({15'h0000, ser_dout_oe}, 16'h0000);
        check({4'h0, code, pd, cur, 1'b0, span}, {4'h0, `OCTL_RESET});
        for (int i = 0; i < 11; i++) begin
            @(negedge ref_clk);
            result_valid = 1'b1;
            result_channel = rows[i].ch;
            result_data = rows[i].val;
            @(negedge ref_clk);
            result_valid = 1'b0;
            host.frame(16'h0000, rows[i].ch, (i % 2) + 2, rd);
            check(rd, {4'h0, rows[i].val});
        end
        wr(16'hE5A5);
        check({4'h0, code, pd, cur, 1'b0, span}, 16'h05A5);
        host.frame(16'h0000, `OCTL_RADDR, 2, rd);
        check(rd, 16'h05A5);
        wr(16'hEA38);
        check({4'h0, code, pd, cur, 1'b0, span}, 16'h0A38);
        wr(16'hF0A5);
        check({8'h00, pin}, 16'h00A5);
        wr(16'hF05A);
        check({8'h00, pin}, 16'h005A);
        wr(16'hF1FF);
        wr(16'hDFFF);
        host.frame(16'h0000, `GPC1_RADDR, 3, rd);
        check(rd, 16'h005A);
        check({4'h0, code, pd, cur, 1'b0, span}, 16'h0A38);
        host.frame(16'h0000, rows[0].ch, 2, rd);
        check(rd, {4'h0, rows[0].val});
        // A strobe while the enable is low must be ignored
        @(negedge ref_clk);
        clk_en = 1'b0;
        result_valid = 1'b1;
        result_channel = `RES_VPOS_RADDR;
        result_data = 12'h0AA;
        @(negedge ref_clk);
        result_valid = 1'b0;
        clk_en = 1'b1;
        host.frame(16'h0000, `RES_VPOS_RADDR, 2, rd);
        check(rd, {4'h0, rows[0].val});
        host.frame(16'h0000, 5'h1C, 2, rd);
        check(rd, 16'h0000);
        // Second reset in mid-run
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        check({4'h0, code, pd, cur, 1'b0, span}, 16'h0008);
        check({8'h00, pin}, 16'h0000);
        for (int i = 0; i < 11; i++) begin
            host.frame(16'h0000, rows[i].ch, 2, rd);
            check(rd, 16'h0000);
        end
        host.frame(16'h0000, `GPC1_RADDR, 2, rd);
        check(rd, 16'h0000);
        end_sim();
    end
endmodule // touch_adc_result_dac_gpio_regs_bench
